// [bench/testbench.sv]
/*
  Self-checking bench for the virtual channel capability register block (vcc_regs).
  Assumes zero-wait APB answers, a strap held steady through reset, and one-cycle pulses
  on the EEPROM, table-write and table-done inputs, all driven on the rising edge.
*/
`timescale 1ns/10ps
module testbench
  import vcc_pkg::*;
;
  logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, second_vc_strap_i, ee_load_i;
  logic [2:0]  ee_ext_vc_i, ee_low_priority_vc_group_i, arb_sel_o, ext_vc_count_o, low_priority_vc_group_o;
  logic        tbl_entry_wr_i, tbl_load_done_i, arb_load_o, tbl_status_o, ref_tick_o;
  int          miscompares, compares, cycles;

  vcc_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .second_vc_strap_i(second_vc_strap_i), .ee_load_i(ee_load_i),
    .ee_ext_vc_i(ee_ext_vc_i), .ee_low_priority_vc_group_i(ee_low_priority_vc_group_i), .tbl_entry_wr_i(tbl_entry_wr_i),
    .tbl_load_done_i(tbl_load_done_i), .arb_load_o(arb_load_o), .arb_sel_o(arb_sel_o),
    .ext_vc_count_o(ext_vc_count_o), .low_priority_vc_group_o(low_priority_vc_group_o),
    .tbl_status_o(tbl_status_o), .ref_tick_o(ref_tick_o));

  // ==========================================================================
  // clock, time-zero values and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, ee_load_i} = 5'h10;
    {paddr_i, pwdata_i, pstrb_i} = '0;
    {second_vc_strap_i, tbl_entry_wr_i, tbl_load_done_i} = 3'h4;
    {ee_ext_vc_i, ee_low_priority_vc_group_i} = 6'h0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
  end
  // whole run needs well under a thousand cycles; a stuck wait ends here
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // common tasks
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     input logic [3:0] strb, output logic [31:0] rdata, output logic err);
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= addr;
    pwdata_i <= wdata;
    pstrb_i  <= strb;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // no local limit: only the bench timeout ends a wait for pready
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge sys_clk_i);
    end
    rdata = prdata_o;
    err   = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i  <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, d, e);
    chk(name, d, exp);
    chk({name, " err"}, {31'h0, e}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, s, q, e);
    chk("write err", {31'h0, e}, {31'h0, exp_err});
  endtask

  // strap is set with reset asserted so it is long settled at release
  task automatic do_reset(input logic strap);
    rst_i             <= 1'b1;
    second_vc_strap_i <= strap;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_vals();
    rd("header", OFF_CAP_HDR, 32'h20c10002, 1'b0);
    rd("cap1", OFF_PVC_CAP1, 32'h00000801, 1'b0);
    rd("cap2", OFF_PVC_CAP2, 32'h03000003, 1'b0);
    rd("ctrl", OFF_PVC_CTRL, 32'h0, 1'b0);
    chk("ext out", {29'h0, ext_vc_count_o}, 32'h1);
  endtask

  // read-only words take all-ones writes silently; unmapped space errors
  task automatic t_ro();
    wr(OFF_CAP_HDR, 32'hffffffff, 4'hf, 1'b0);
    wr(OFF_PVC_CAP1, 32'hffffffff, 4'hf, 1'b0);
    wr(OFF_PVC_CAP2, 32'hffffffff, 4'hf, 1'b0);
    t_reset_vals();
    rd("unmapped", 12'h150, 32'h0, 1'b1);
    wr(12'h150, 32'hffffffff, 4'hf, 1'b1);
  endtask

  // every select code, reserved bits set, load bit set each time
  task automatic t_control();
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wr(OFF_PVC_CTRL, {28'hfffffff, v, 1'b1}, 4'hf, 1'b0);
      #1 chk("load pulse", {31'h0, arb_load_o}, 32'h1);
      @(posedge sys_clk_i);
      #1 chk("load end", {31'h0, arb_load_o}, 32'h0);
      chk("sel out", {29'h0, arb_sel_o}, (v <= 3'h1) ? {29'h0, v} : 0);
      rd("ctrl", OFF_PVC_CTRL, {28'h0, v, 1'b0}, 1'b0);
    end
    // without lane 0 the control byte must not change nor load
    wr(OFF_PVC_CTRL, 32'h3, 4'he, 1'b0);
    #1 chk("no load", {31'h0, arb_load_o}, 32'h0);
    rd("ctrl kept", OFF_PVC_CTRL, 32'he, 1'b0);
  endtask

  task automatic t_table();
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b1;
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b0;
    @(posedge sys_clk_i) tbl_entry_wr_i <= 1'b1;
    @(posedge sys_clk_i) tbl_entry_wr_i <= 1'b0;
    #1 chk("status set", {31'h0, tbl_status_o}, 32'h1);
    // a done with no load pending must leave the flag alone
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b1;
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b0;
    rd("ctrl status", OFF_PVC_CTRL, 32'h0001000e, 1'b0);
    wr(OFF_PVC_CTRL, 32'h1, 4'h1, 1'b0);
    rd("still set", OFF_PVC_CTRL, 32'h00010000, 1'b0);
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b1;
    @(posedge sys_clk_i) tbl_load_done_i <= 1'b0;
    #1 chk("status clear", {31'h0, tbl_status_o}, 32'h0);
    rd("ctrl clear", OFF_PVC_CTRL, 32'h0, 1'b0);
    // entry write and load finish in one cycle: the set wins
    wr(OFF_PVC_CTRL, 32'h1, 4'h1, 1'b0);
    @(posedge sys_clk_i) {tbl_entry_wr_i, tbl_load_done_i} <= 2'h3;
    @(posedge sys_clk_i) {tbl_entry_wr_i, tbl_load_done_i} <= 2'h0;
    #1 chk("set wins", {31'h0, tbl_status_o}, 32'h1);
  endtask

  task automatic eload(input logic [2:0] ext, input logic [2:0] lp);
    @(posedge sys_clk_i);
    ee_ext_vc_i <= ext;
    ee_low_priority_vc_group_i   <= lp;
    ee_load_i   <= 1'b1;
    @(posedge sys_clk_i) ee_load_i <= 1'b0;
    #1 chk("ext out", {29'h0, ext_vc_count_o}, {29'h0, ext});
    chk("low out", {29'h0, low_priority_vc_group_o}, {29'h0, lp});
    rd("cap1 ee", OFF_PVC_CAP1, {20'h0, 4'h8, 1'b0, lp, 1'b0, ext}, 1'b0);
    rd("cap2 ee", OFF_PVC_CAP2, ext[0] ? 32'h03000003 : 32'h0, 1'b0);
  endtask

  task automatic t_strap0();
    do_reset(1'b0);
    rd("cap1 s0", OFF_PVC_CAP1, 32'h00000800, 1'b0);
    rd("cap2 s0", OFF_PVC_CAP2, 32'h0, 1'b0);
  endtask

  // 100 ns reference at a 10 ns clock is one tick every ten edges
  task automatic t_tick();
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (ref_tick_o !== 1'b1 && n < 30) begin
      n++;
      @(posedge sys_clk_i);
    end
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ref_tick_o !== 1'b1 && n < 30);
    chk("tick period", 32'(n), 32'd10);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    do_reset(1'b1);
    t_reset_vals();
    t_ro();
    t_control();
    t_table();
    eload(3'h6, 3'h5);
    eload(3'h1, 3'h0);
    t_strap0();
    t_tick();
    conclude();
  end
endmodule // testbench

// [design/vcc_apb_slave.sv]
/*
  APB protocol slave: takes read data at the setup edge, answers in the first access cycle.
  Assumes the register core decodes paddr combinationally and acts on wr_o.
*/
`timescale 1ns/10ps
module vcc_apb_slave
  import vcc_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire vcc_apb_req_s req_i,
  input  wire logic [31:0]  rdata_i,
  input  wire logic         hit_i,
  output vcc_apb_rsp_s      rsp_o,
  output logic              wr_o
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        err;
  } vcc_apb_st_s;

  vcc_apb_st_s r;
  vcc_apb_st_s nxt;
  logic        setup;

  // ==========================================================================
  // capture at setup so read data comes straight from flip-flops
  assign setup = req_i.psel && !req_i.penable;

  always_comb begin
    nxt = r;
    if (setup) begin
      nxt.prdata = (!req_i.pwrite && hit_i) ? rdata_i : 32'h0000_0000;
      nxt.err    = !hit_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // zero wait states: the access phase always completes in its first cycle
  assign rsp_o.pready  = req_i.psel && req_i.penable;
  assign rsp_o.prdata  = r.prdata;
  assign rsp_o.pslverr = r.err && req_i.psel && req_i.penable;
  assign wr_o          = req_i.psel && req_i.penable && req_i.pwrite;
endmodule // vcc_apb_slave

// [design/vcc_pkg.sv]
/*
  Shared constants and carrier types for the virtual channel capability register block.
  Assumes a 100 MHz core clock and 32-bit APB with byte addresses on a 12-bit bus.
*/
package vcc_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] OFF_CAP_HDR  = 12'h140;
  localparam logic [11:0] OFF_PVC_CAP1 = 12'h144;
  localparam logic [11:0] OFF_PVC_CAP2 = 12'h148;
  localparam logic [11:0] OFF_PVC_CTRL = 12'h14c;
  // ==========================================================================
  // field positions
  localparam int CAP_ID_LSB  = 0;
  localparam int CAP_VER_LSB = 16;
  localparam int NEXT_LSB    = 20;
  localparam int EXT_VC_LSB  = 0;
  localparam int LOW_PRIORITY_VC_GROUP_LSB    = 4;
  localparam int REFCLK_LSB  = 8;
  localparam int ENTRY_LSB   = 10;
  localparam int ARBCAP_LSB  = 0;
  localparam int TBLOFF_LSB  = 24;
  localparam int LOAD_BIT    = 0;
  localparam int SEL_LSB     = 1;
  localparam int TSTAT_BIT   = 16;
  // ==========================================================================
  // fixed values and reset values
  localparam logic [15:0] CAP_ID       = 16'h0002;
  localparam logic [3:0]  CAP_VER      = 4'h1;
  localparam logic [11:0] NEXT_PTR     = 12'h20c;
  localparam logic [1:0]  EXT_HI_RST   = 2'h0;
  localparam logic [2:0]  LOW_PRIORITY_VC_GROUP_RST     = 3'h0;
  localparam logic [1:0]  REFCLK_100NS = 2'h0;
  localparam logic [1:0]  ENTRY_4BIT   = 2'h2;
  localparam logic [7:0]  ARBCAP_ON    = 8'h03;
  localparam logic [7:0]  ARBCAP_OFF   = 8'h00;
  localparam logic [7:0]  TBLOFF_ON    = 8'h03;
  localparam logic [7:0]  TBLOFF_OFF   = 8'h00;
  localparam logic [2:0]  SEL_RST      = 3'h0;
  localparam logic [2:0]  SEL_MAX      = 3'h1;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_CLK_NS    = 100;
  localparam int REF_CLK_CYC   = REF_CLK_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    VCC_IDLE    = 2'h0,
    VCC_LOADING = 2'h1
  } vcc_load_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } vcc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vcc_apb_rsp_s;
endpackage

// [design/vcc_regs.sv]
/*
  Virtual channel capability register block of one switch port: capability header,
  two port VC capability words and the port VC control/status word, over APB.
  Assumes a configuration EEPROM loader on the same clock, a strap pin from outside,
  and arbitration hardware that reports when it has taken a loaded table.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module vcc_regs
  import vcc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // apb slave port
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // strap pin and EEPROM autoload
  input  wire logic        second_vc_strap_i,
  input  wire logic        ee_load_i,
  input  wire logic [2:0]  ee_ext_vc_i,
  input  wire logic [2:0]  ee_low_priority_vc_group_i,
  // arbitration hardware side
  input  wire logic        tbl_entry_wr_i,
  input  wire logic        tbl_load_done_i,
  output logic             arb_load_o,
  output logic [2:0]       arb_sel_o,
  output logic [2:0]       ext_vc_count_o,
  output logic [2:0]       low_priority_vc_group_o,
  output logic             tbl_status_o,
  output logic             ref_tick_o
);
  localparam int TICK_GAP = REF_CLK_CYC;

  typedef struct packed {
    logic [1:0] ext_hi;
    logic       ext_b0;
    logic [2:0] low_priority_vc_group;
    logic [2:0] sel;
    logic       tstat;
    logic       load_p;
    vcc_load_e  st;
    logic       strap_done;
    logic [3:0] ref_cnt;
    logic       ref_tick;
  } vcc_regs_s;

  localparam vcc_regs_s RST = '{
    ext_hi:     EXT_HI_RST,
    ext_b0:     1'b0,
    low_priority_vc_group:       LOW_PRIORITY_VC_GROUP_RST,
    sel:        SEL_RST,
    tstat:      1'b0,
    load_p:     1'b0,
    st:         VCC_IDLE,
    strap_done: 1'b0,
    ref_cnt:    4'h0,
    ref_tick:   1'b0
  };

  vcc_regs_s    r;
  vcc_regs_s    nxt;
  vcc_apb_req_s req;
  vcc_apb_rsp_s rsp;
  logic [31:0]  rd_word;
  logic         hit;
  logic         wr;
  logic         ctrl_wr;
  logic         strap_s;

  // ==========================================================================
  // address decode, shared by the read mux and the error answer
  function automatic logic map_hit(input logic [11:0] a);
    return (a == OFF_CAP_HDR) || (a == OFF_PVC_CAP1) ||
           (a == OFF_PVC_CAP2) || (a == OFF_PVC_CTRL);
  endfunction

  // select values outside the supported set fall back to the default scheme
  function automatic logic [2:0] eff_sel(input logic [2:0] s);
    return (s <= SEL_MAX) ? s : SEL_RST;
  endfunction

  // ==========================================================================
  // bus protocol and strap synchroniser
  assign req.psel    = psel_i;
  assign req.penable = penable_i;
  assign req.pwrite  = pwrite_i;
  assign req.paddr   = paddr_i;
  assign req.pwdata  = pwdata_i;
  assign req.pstrb   = pstrb_i;
  assign hit         = map_hit(paddr_i);

  vcc_apb_slave u_apb (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .req_i     (req),
    .rdata_i   (rd_word),
    .hit_i     (hit),
    .rsp_o     (rsp),
    .wr_o      (wr)
  );

  vcc_sync2 u_strap (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (second_vc_strap_i),
    .sync_o    (strap_s)
  );

  assign prdata_o  = rsp.prdata;
  assign pready_o  = rsp.pready;
  assign pslverr_o = rsp.pslverr;

  // only the control word is writable, and only its low byte holds writable fields
  assign ctrl_wr = wr && (paddr_i == OFF_PVC_CTRL) && pstrb_i[0];

  // ==========================================================================
  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr_i)
      OFF_CAP_HDR: begin
        rd_word[CAP_ID_LSB +: 16] = CAP_ID;
        rd_word[CAP_VER_LSB +: 4] = CAP_VER;
        rd_word[NEXT_LSB +: 12]   = NEXT_PTR;
      end
      OFF_PVC_CAP1: begin
        rd_word[EXT_VC_LSB +: 3] = {r.ext_hi, r.ext_b0};
        rd_word[LOW_PRIORITY_VC_GROUP_LSB +: 3]   = r.low_priority_vc_group;
        rd_word[REFCLK_LSB +: 2] = REFCLK_100NS;
        rd_word[ENTRY_LSB +: 2]  = ENTRY_4BIT;
      end
      OFF_PVC_CAP2: begin
        rd_word[ARBCAP_LSB +: 8] = r.ext_b0 ? ARBCAP_ON : ARBCAP_OFF;
        rd_word[TBLOFF_LSB +: 8] = r.ext_b0 ? TBLOFF_ON : TBLOFF_OFF;
      end
      OFF_PVC_CTRL: begin
        rd_word[LOAD_BIT]     = 1'b0;
        rd_word[SEL_LSB +: 3] = r.sel;
        rd_word[TSTAT_BIT]    = r.tstat;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // next state of every register of the block
  always_comb begin
    nxt        = r;
    nxt.load_p = 1'b0;
    // strap is sampled once, on the first cycle after reset
    if (!r.strap_done) begin
      nxt.ext_b0     = strap_s;
      nxt.strap_done = 1'b1;
    end
    // EEPROM autoload comes later and overrides the strap value
    if (ee_load_i) begin
      {nxt.ext_hi, nxt.ext_b0} = ee_ext_vc_i;
      nxt.low_priority_vc_group                 = ee_low_priority_vc_group_i;
    end
    // control word write: the load bit is a command, never stored
    if (ctrl_wr) begin
      nxt.sel = pwdata_i[SEL_LSB +: 3];
      if (pwdata_i[LOAD_BIT]) begin
        nxt.load_p = 1'b1;
      end
    end
    // table load tracking
    case (r.st)
      VCC_IDLE: begin
        if (nxt.load_p) begin
          nxt.st = VCC_LOADING;
        end
      end
      VCC_LOADING: begin
        if (tbl_load_done_i) begin
          nxt.st    = VCC_IDLE;
          nxt.tstat = 1'b0;
        end
      end
      default: nxt.st = VCC_IDLE;
    endcase
    // an entry write in the same cycle as the done wins over the clear
    if (tbl_entry_wr_i) begin
      nxt.tstat = 1'b1;
    end
    // 100 ns reference tick for time-based arbitration
    if (r.ref_cnt == 4'(REF_CLK_CYC - 1)) begin
      nxt.ref_cnt  = 4'h0;
      nxt.ref_tick = 1'b1;
    end else begin
      nxt.ref_cnt  = r.ref_cnt + 4'h1;
      nxt.ref_tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r <= RST;
    end else begin
      r <= nxt;
    end
  end

  // ==========================================================================
  // outputs to the arbitration hardware, all from flip-flops except arb_sel_o, which passes r.sel through eff_sel
  assign arb_load_o              = r.load_p;
  assign arb_sel_o               = eff_sel(r.sel);
  assign ext_vc_count_o          = {r.ext_hi, r.ext_b0};
  assign low_priority_vc_group_o = r.low_priority_vc_group;
  assign tbl_status_o            = r.tstat;
  assign ref_tick_o              = r.ref_tick;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_setup(logic [11:0] a);
    psel_i && !penable_i && !pwrite_i && (paddr_i == a);
  endsequence

  sequence s_load_req;
    ctrl_wr && pwdata_i[LOAD_BIT];
  endsequence

  // hardware reports the table taken while a load is pending, with no new entry write
  sequence s_load_finish;
    (r.st == VCC_LOADING) && tbl_load_done_i && !tbl_entry_wr_i;
  endsequence

  sequence s_access;
    psel_i && penable_i;
  endsequence

  property p_hdr_id;
    s_rd_setup(OFF_CAP_HDR) |=> prdata_o[CAP_ID_LSB +: 16] == CAP_ID;
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("header id wrong");

  property p_hdr_ver;
    s_rd_setup(OFF_CAP_HDR) |=> prdata_o[CAP_VER_LSB +: 4] == CAP_VER;
  endproperty
  a_hdr_ver: assert property (p_hdr_ver) else $error("header version wrong");

  property p_hdr_next;
    s_rd_setup(OFF_CAP_HDR) |=> prdata_o[NEXT_LSB +: 12] == NEXT_PTR;
  endproperty
  a_hdr_next: assert property (p_hdr_next) else $error("next pointer wrong");

  property p_strap;
    !r.strap_done && !ee_load_i |=> ext_vc_count_o == {EXT_HI_RST, $past(strap_s)};
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_ee_load;
    ee_load_i |=> ext_vc_count_o == $past(ee_ext_vc_i);
  endproperty
  a_ee_load: assert property (p_ee_load) else $error("EEPROM count not loaded");

  property p_ee_low_priority_vc_group;
    s_rd_setup(OFF_PVC_CAP1) ##0 !ee_load_i |=>
      prdata_o[LOW_PRIORITY_VC_GROUP_LSB +: 3] == low_priority_vc_group_o;
  endproperty
  a_ee_low_priority_vc_group: assert property (p_ee_low_priority_vc_group) else $error("low priority count wrong");

  property p_ref_tick;
    ref_tick_o |=> !ref_tick_o ##(TICK_GAP - 1) ref_tick_o;
  endproperty
  a_ref_tick: assert property (p_ref_tick) else $error("reference tick period wrong");

  property p_cap1_fixed;
    s_rd_setup(OFF_PVC_CAP1) |=> prdata_o[11:8] == {ENTRY_4BIT, REFCLK_100NS};
  endproperty
  a_cap1_fixed: assert property (p_cap1_fixed) else $error("capability fixed bits");

  property p_cap1_rsvd;
    s_rd_setup(OFF_PVC_CAP1) |=>
      prdata_o[31:12] == 20'h00000 && !prdata_o[7] && !prdata_o[3];
  endproperty
  a_cap1_rsvd: assert property (p_cap1_rsvd) else $error("reserved bits not zero");

  property p_cap2;
    s_rd_setup(OFF_PVC_CAP2) |=> prdata_o == ($past(ext_vc_count_o[0]) ?
      {TBLOFF_ON, 16'h0000, ARBCAP_ON} : {TBLOFF_OFF, 16'h0000, ARBCAP_OFF});
  endproperty
  a_cap2: assert property (p_cap2) else $error("second capability word wrong");

  property p_load;
    s_load_req |=> arb_load_o ##1 !arb_load_o;
  endproperty
  a_load: assert property (p_load) else $error("load pulse missing");

  property p_ctrl_rd;
    s_rd_setup(OFF_PVC_CTRL) |=> prdata_o[LOAD_BIT] == 1'b0 && prdata_o[15:4] == 12'h000;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  property p_sel;
    ctrl_wr && pwdata_i[3:1] > SEL_MAX |=> arb_sel_o == SEL_RST;
  endproperty
  a_sel: assert property (p_sel) else $error("select not defaulted");

  property p_tstat_set;
    tbl_entry_wr_i |=> tbl_status_o;
  endproperty
  a_tstat_set: assert property (p_tstat_set) else $error("table status not set");

  property p_tstat_clr;
    s_load_finish |=> !tbl_status_o;
  endproperty
  a_tstat_clr: assert property (p_tstat_clr) else $error("table status not cleared");

  // with no load pending a done report must leave the flag alone
  property p_tstat_hold;
    (r.st == VCC_IDLE) && !tbl_entry_wr_i |=> $stable(tbl_status_o);
  endproperty
  a_tstat_hold: assert property (p_tstat_hold) else $error("status moved in idle");

  property p_access_err;
    s_access |-> pslverr_o == !map_hit(paddr_i);
  endproperty
  a_access_err: assert property (p_access_err) else $error("error answer wrong");

  property p_ro_write;
    wr && (paddr_i != OFF_PVC_CTRL) && !ee_load_i && r.strap_done |=>
      $stable(ext_vc_count_o) && $stable(arb_sel_o);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");
endmodule // vcc_regs

// [design/vcc_sync2.sv]
/*
  Two-stage synchroniser for a single level from outside the core clock domain.
  Assumes the input is a slow level such as a strap pin.
*/
`timescale 1ns/10ps
module vcc_sync2
  import vcc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } vcc_sync_s;

  vcc_sync_s r;
  vcc_sync_s nxt;

  // ==========================================================================
  // only the second stage is visible outside
  always_comb begin
    nxt    = r;
    nxt.s1 = async_i;
    nxt.s2 = r.s1;
  end

  // no reset on purpose: the chain refills from the pin while reset is held, so the
  // level is already valid at the first edge after release; rst_i is left unused
  always_ff @(posedge sys_clk_i) begin
    r <= nxt;
  end

  assign sync_o = r.s2;
endmodule // vcc_sync2
